// ### rtl/sqm_ctrl.v
// Purpose: Host-side controller for flash sector protection and query-mode reads.
// Assumes: Software issues one operation at a time and polls the busy bit.
// Notes: The device mode and sector protection state are host-side beliefs.
//
// Notes on behaviour
// - Protect and unprotect run with reset pin elevated and ordinary bus cycles.
// - Every sector must be protected before an unprotect write; the host refuses the unprotect unless its copy shows all 35 protected.
// - Query mode entered by 98h to word 55h or byte AAh.
// - Word-mode query reads drive address bit 7 and above to zero.
// - The reset command leaves query mode, back to the mode it was entered from; the ID-enter command also leaves it, for ID mode.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sqm_regs.vh"

module sqm_ctrl
(
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Software register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   // Flash bus pins
   output wire [20:0] fl_addr,
   input wire [15:0] fl_dq_i,
   output wire [15:0] fl_dq_o,
   output wire fl_dq_oe_n,
   output wire fl_ce_n,
   output wire fl_oe_n,
   output wire fl_we_n,
   // Flash control pins
   output reg fl_byte_n_q,
   output reg fl_reset_n_q,
   output reg fl_elevated_voltage_level_q,
   output reg fl_boot_lock_n_q
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_SETTLE = 2'h1;
   localparam [1:0] S_START = 2'h2;
   localparam [1:0] S_WAIT = 2'h3;
   localparam integer HV_CYC = `SQM_HV_CYC;
   localparam [3:0] HV_LIM = HV_CYC[3:0];
   localparam [34:0] ALL_SET = {35{1'b1}};

   reg [2:0] ctrl_q;
   reg [20:0] addr_q;
   reg [15:0] wdata_q;
   reg [5:0] sector_q;
   reg [15:0] rdata_q;
   reg [1:0] state_q;
   reg [3:0] op_q;
   reg [3:0] cnt_q;
   reg [1:0] mode_q;
   reg [1:0] prev_mode_q;
   reg refused_q;
   reg [2:0] qry_seen_q;
   reg hv_op_q;
   reg start_q;
   reg cyc_wr_q;
   reg [20:0] cyc_addr_q;
   reg [15:0] cyc_data_q;
   reg [34:0] shadow_q;
   reg [31:0] rd_d;
   reg [20:0] op_addr_d;
   reg op_ok_d;
   wire byte_mode;
   wire cmd_wr;
   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire [6:0] qry_waddr;
   wire [7:0] rbyte;

   assign byte_mode = ctrl_q[`SQM_CTRL_BYTE_MODE];
   assign cmd_wr = reg_wr && (reg_addr == `SQM_OFF_CMD);
   assign qry_waddr = byte_mode ? addr_q[7:1] : addr_q[6:0];
   assign rbyte = cyc_rdata[7:0];

   // Address that the requested operation drives on the pins.
   always @*
   begin
      op_addr_d = addr_q;
      case (reg_wdata[3:0])
         `SQM_OP_QUERY:
         begin
            op_addr_d = byte_mode ? `SQM_QUERY_ADDR_BYTE : `SQM_QUERY_ADDR_WORD;
         end
         `SQM_OP_READ:
         begin
            if ((mode_q == `SQM_MODE_QUERY) && !byte_mode)
            begin
               op_addr_d = {14'h0000, addr_q[6:0]};
            end
         end
         `SQM_OP_VERIFY:
         begin
            // Software gives the sector base; low bits select the verify location.
            if (byte_mode)
            begin
               op_addr_d = {addr_q[20:3], `SQM_VERIFY_LOW_BYTE};
            end
            else
            begin
               op_addr_d = {addr_q[20:2], `SQM_VERIFY_LOW_WORD};
            end
         end
         default:
         begin
            op_addr_d = addr_q;
         end
      endcase
   end

   // Legality of the requested operation against the tracked mode, or for unprotect against the host protection copy.
   always @*
   begin
      op_ok_d = 1'b1;
      case (reg_wdata[3:0])
         `SQM_OP_QUERY:
         begin
            op_ok_d = (mode_q != `SQM_MODE_QUERY);
         end
         `SQM_OP_VERIFY:
         begin
            op_ok_d = (mode_q == `SQM_MODE_ID);
         end
         `SQM_OP_UNPROTECT:
         begin
            op_ok_d = (shadow_q == ALL_SET);
         end
         `SQM_OP_WRITE, `SQM_OP_READ, `SQM_OP_RESET, `SQM_OP_ID_ENTER, `SQM_OP_PROTECT:
         begin
            op_ok_d = 1'b1;
         end
         default:
         begin
            op_ok_d = 1'b0;
         end
      endcase
   end

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_q <= `SQM_CTRL_RESET;
         addr_q <= 21'h000000;
         wdata_q <= 16'h0000;
         sector_q <= 6'h00;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `SQM_OFF_CTRL: ctrl_q <= reg_wdata[2:0];
            `SQM_OFF_ADDR: addr_q <= reg_wdata[20:0];
            `SQM_OFF_WDATA: wdata_q <= reg_wdata[15:0];
            `SQM_OFF_SECTOR: sector_q <= reg_wdata[5:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Operation sequencer and tracked device mode.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= S_IDLE;
         op_q <= 4'h0;
         cnt_q <= 4'h0;
         mode_q <= `SQM_MODE_ARRAY;
         prev_mode_q <= `SQM_MODE_ARRAY;
         refused_q <= 1'b0;
         qry_seen_q <= 3'h0;
         hv_op_q <= 1'b0;
         start_q <= 1'b0;
         cyc_wr_q <= 1'b0;
         cyc_addr_q <= 21'h000000;
         cyc_data_q <= 16'h0000;
         rdata_q <= 16'h0000;
      end
      else
      begin
         start_q <= 1'b0;
         // A refusal in the same cycle as the clear wins over the clear.
         if (reg_wr && (reg_addr == `SQM_OFF_STATUS) && reg_wdata[`SQM_ST_REFUSED])
         begin
            refused_q <= 1'b0;
         end
         case (state_q)
            S_IDLE:
            begin
               if (cmd_wr)
               begin
                  if (!op_ok_d)
                  begin
                     refused_q <= 1'b1;
                  end
                  else if (reg_wdata[3:0] == `SQM_OP_ID_ENTER)
                  begin
                     // Software has already sent its identification sequence.
                     mode_q <= `SQM_MODE_ID;
                  end
                  else
                  begin
                     op_q <= reg_wdata[3:0];
                     cyc_addr_q <= op_addr_d;
                     cyc_wr_q <= (reg_wdata[3:0] != `SQM_OP_READ) && (reg_wdata[3:0] != `SQM_OP_VERIFY);
                     cyc_data_q <= (reg_wdata[3:0] == `SQM_OP_QUERY) ? {8'h00, `SQM_QUERY_CMD} : wdata_q;
                     cnt_q <= 4'h0;
                     if ((reg_wdata[3:0] == `SQM_OP_PROTECT) || (reg_wdata[3:0] == `SQM_OP_UNPROTECT))
                     begin
                        hv_op_q <= 1'b1;
                        state_q <= S_SETTLE;
                     end
                     else
                     begin
                        state_q <= S_START;
                     end
                  end
               end
            end
            S_SETTLE:
            begin
               // The elevated level must settle before the procedure's bus cycle.
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q + 4'h1 == HV_LIM)
               begin
                  state_q <= S_START;
               end
            end
            S_START:
            begin
               start_q <= 1'b1;
               state_q <= S_WAIT;
            end
            S_WAIT:
            begin
               if (cyc_done)
               begin
                  state_q <= S_IDLE;
                  hv_op_q <= 1'b0;
                  if (!cyc_wr_q)
                  begin
                     rdata_q <= cyc_rdata;
                  end
                  case (op_q)
                     `SQM_OP_QUERY:
                     begin
                        prev_mode_q <= mode_q;
                        mode_q <= `SQM_MODE_QUERY;
                        qry_seen_q <= 3'h0;
                     end
                     `SQM_OP_RESET:
                     begin
                        // Leaving query goes back where it came from; otherwise to array reads.
                        mode_q <= (mode_q == `SQM_MODE_QUERY) ? prev_mode_q : `SQM_MODE_ARRAY;
                     end
                     `SQM_OP_READ:
                     begin
                        if (mode_q == `SQM_MODE_QUERY)
                        begin
                           if ((qry_waddr == `SQM_QRY_WADDR0) && (rbyte == `SQM_QRY_CHAR0))
                           begin
                              qry_seen_q[0] <= 1'b1;
                           end
                           if ((qry_waddr == `SQM_QRY_WADDR1) && (rbyte == `SQM_QRY_CHAR1))
                           begin
                              qry_seen_q[1] <= 1'b1;
                           end
                           if ((qry_waddr == `SQM_QRY_WADDR2) && (rbyte == `SQM_QRY_CHAR2))
                           begin
                              qry_seen_q[2] <= 1'b1;
                           end
                        end
                     end
                     default:
                     begin
                        mode_q <= mode_q;
                     end
                  endcase
               end
            end
            default:
            begin
               state_q <= S_IDLE;
            end
         endcase
         if (cmd_wr && (state_q != S_IDLE))
         begin
            refused_q <= 1'b1;
         end
      end
   end

   // Host copy of each sector's protection state, starting unprotected.
   genvar gi;
   generate
      for (gi = 0; gi < `SQM_SECTORS; gi = gi + 1)
      begin : g_shadow
         always @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               shadow_q[gi] <= 1'b0;
            end
            else if ((state_q == S_WAIT) && cyc_done)
            begin
               if ((op_q == `SQM_OP_UNPROTECT))
               begin
                  shadow_q[gi] <= 1'b0;
               end
               else if ((op_q == `SQM_OP_PROTECT) && (sector_q == gi))
               begin
                  shadow_q[gi] <= 1'b1;
               end
               else if ((op_q == `SQM_OP_VERIFY) && (sector_q == gi))
               begin
                  shadow_q[gi] <= (cyc_rdata[7:0] == `SQM_VERIFY_PROTECTED);
               end
            end
         end
      end
   endgenerate

   // Pin levels; elevated level is held for the temporary mode or a procedure.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fl_byte_n_q <= 1'b1;
         fl_reset_n_q <= 1'b0;
         fl_elevated_voltage_level_q <= 1'b0;
         fl_boot_lock_n_q <= 1'b0;
      end
      else
      begin
         fl_byte_n_q <= !byte_mode;
         fl_reset_n_q <= 1'b1;
         fl_elevated_voltage_level_q <= ctrl_q[`SQM_CTRL_TEMP_UNPROT] || hv_op_q;
         fl_boot_lock_n_q <= ctrl_q[`SQM_CTRL_BOOT_RELEASE];
      end
   end

   always @*
   begin
      rd_d = 32'h00000000;
      case (reg_addr)
         `SQM_OFF_CTRL: rd_d = {29'h00000000, ctrl_q};
         `SQM_OFF_ADDR: rd_d = {11'h000, addr_q};
         `SQM_OFF_WDATA: rd_d = {16'h0000, wdata_q};
         `SQM_OFF_STATUS: rd_d = {26'h0000000, fl_elevated_voltage_level_q, (qry_seen_q == 3'h7), refused_q,
                                  mode_q, (state_q != S_IDLE)};
         `SQM_OFF_RDATA: rd_d = {16'h0000, rdata_q};
         `SQM_OFF_SHADOW_LO: rd_d = shadow_q[31:0];
         `SQM_OFF_SHADOW_HI: rd_d = {29'h00000000, shadow_q[34:32]};
         `SQM_OFF_SECTOR: rd_d = {26'h0000000, sector_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata_q <= 32'h00000000;
      end
      else if (reg_rd)
      begin
         reg_rdata_q <= rd_d;
      end
   end

   sqm_cycle u_cycle
   (
      .clock(clock),
      .arst_n(arst_n),
      .start(start_q),
      .is_wr(cyc_wr_q),
      .addr_i(cyc_addr_q),
      .data_i(cyc_data_q),
      .done_q(cyc_done),
      .rdata_q(cyc_rdata),
      .fl_addr_q(fl_addr),
      .fl_dq_i(fl_dq_i),
      .fl_dq_o_q(fl_dq_o),
      .fl_dq_oe_n_q(fl_dq_oe_n),
      .fl_ce_n_q(fl_ce_n),
      .fl_oe_n_q(fl_oe_n),
      .fl_we_n_q(fl_we_n)
   );

endmodule

// ### pkg/sqm_regs.vh
// Purpose: Constants for the sector-protect and query-mode flash controller.
// Assumes: 50 MHz clock; register port with 4-bit word index and 32-bit data.
// Notes: Timing counts are derived from times in nanoseconds.
`ifndef SQM_REGS_VH
`define SQM_REGS_VH

// Register indices on the software port.
`define SQM_OFF_CTRL 4'h0
`define SQM_OFF_ADDR 4'h1
`define SQM_OFF_WDATA 4'h2
`define SQM_OFF_CMD 4'h3
`define SQM_OFF_STATUS 4'h4
`define SQM_OFF_RDATA 4'h5
`define SQM_OFF_SHADOW_LO 4'h6
`define SQM_OFF_SHADOW_HI 4'h7
`define SQM_OFF_SECTOR 4'h8

// Control register fields and reset value.
`define SQM_CTRL_BYTE_MODE 0
`define SQM_CTRL_BOOT_RELEASE 1
`define SQM_CTRL_TEMP_UNPROT 2
`define SQM_CTRL_RESET 3'h0

// Status register fields.
`define SQM_ST_BUSY 0
`define SQM_ST_MODE_LO 1
`define SQM_ST_MODE_HI 2
`define SQM_ST_REFUSED 3
`define SQM_ST_QRY_OK 4
`define SQM_ST_ELEVATED 5

// Operation codes written to the command register.
`define SQM_OP_WRITE 4'h1
`define SQM_OP_READ 4'h2
`define SQM_OP_QUERY 4'h3
`define SQM_OP_RESET 4'h4
`define SQM_OP_ID_ENTER 4'h5
`define SQM_OP_VERIFY 4'h6
`define SQM_OP_PROTECT 4'h7
`define SQM_OP_UNPROTECT 4'h8

// Tracked device read modes.
`define SQM_MODE_ARRAY 2'h0
`define SQM_MODE_ID 2'h1
`define SQM_MODE_QUERY 2'h2

// Query entry and table constants.
`define SQM_QUERY_CMD 8'h98
`define SQM_QUERY_ADDR_WORD 21'h000055
`define SQM_QUERY_ADDR_BYTE 21'h0000aa
`define SQM_QRY_WADDR0 7'h10
`define SQM_QRY_WADDR1 7'h11
`define SQM_QRY_WADDR2 7'h12
`define SQM_QRY_CHAR0 8'h51
`define SQM_QRY_CHAR1 8'h52
`define SQM_QRY_CHAR2 8'h59
`define SQM_VERIFY_PROTECTED 8'h01
`define SQM_VERIFY_LOW_WORD 2'h2
`define SQM_VERIFY_LOW_BYTE 3'h4
`define SQM_SECTORS 35

// Timing.
`define SQM_CLK_NS 20
`define SQM_T_ACC_NS 70
`define SQM_T_WP_NS 40
`define SQM_T_HV_SETTLE_NS 200
`define SQM_ACC_CYC ((`SQM_T_ACC_NS + `SQM_CLK_NS - 1) / `SQM_CLK_NS)
`define SQM_WP_CYC ((`SQM_T_WP_NS + `SQM_CLK_NS - 1) / `SQM_CLK_NS)
`define SQM_HV_CYC ((`SQM_T_HV_SETTLE_NS + `SQM_CLK_NS - 1) / `SQM_CLK_NS)

`endif

// ### rtl/sqm_cycle.v
// Purpose: One asynchronous flash bus cycle, read or write, on the device pins.
// Assumes: Start is a one-cycle pulse taken only while no cycle is running.
// Notes: Read data pass two flip-flops, so the read window is stretched by two.
`timescale 1ns/1ps
`include "sqm_regs.vh"

module sqm_cycle
(
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Request and answer
   input wire start,
   input wire is_wr,
   input wire [20:0] addr_i,
   input wire [15:0] data_i,
   output reg done_q,
   output reg [15:0] rdata_q,
   // Flash pins
   output reg [20:0] fl_addr_q,
   input wire [15:0] fl_dq_i,
   output reg [15:0] fl_dq_o_q,
   output reg fl_dq_oe_n_q,
   output reg fl_ce_n_q,
   output reg fl_oe_n_q,
   output reg fl_we_n_q
);

   localparam [2:0] C_IDLE = 3'h0;
   localparam [2:0] C_READ = 3'h1;
   localparam [2:0] C_WSET = 3'h2;
   localparam [2:0] C_WPULSE = 3'h3;
   localparam [2:0] C_WHOLD = 3'h4;
   localparam integer READ_CYC = `SQM_ACC_CYC + 2;
   localparam integer WP_CYC = `SQM_WP_CYC;
   localparam [3:0] READ_LIM = READ_CYC[3:0];
   localparam [3:0] WP_LIM = WP_CYC[3:0];

   reg [2:0] state_q;
   reg [3:0] cnt_q;
   reg [15:0] dq_s1_q;
   reg [15:0] dq_s2_q;

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
      end
      else
      begin
         dq_s1_q <= fl_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= C_IDLE;
         cnt_q <= 4'h0;
         done_q <= 1'b0;
         rdata_q <= 16'h0000;
         fl_addr_q <= 21'h000000;
         fl_dq_o_q <= 16'h0000;
         fl_dq_oe_n_q <= 1'b1;
         fl_ce_n_q <= 1'b1;
         fl_oe_n_q <= 1'b1;
         fl_we_n_q <= 1'b1;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            C_IDLE:
            begin
               cnt_q <= 4'h0;
               if (start)
               begin
                  fl_addr_q <= addr_i;
                  fl_ce_n_q <= 1'b0;
                  if (is_wr)
                  begin
                     fl_dq_o_q <= data_i;
                     fl_dq_oe_n_q <= 1'b0;
                     state_q <= C_WSET;
                  end
                  else
                  begin
                     fl_oe_n_q <= 1'b0;
                     state_q <= C_READ;
                  end
               end
            end
            C_READ:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == READ_LIM)
               begin
                  rdata_q <= dq_s2_q;
                  fl_ce_n_q <= 1'b1;
                  fl_oe_n_q <= 1'b1;
                  done_q <= 1'b1;
                  state_q <= C_IDLE;
               end
            end
            C_WSET:
            begin
               fl_we_n_q <= 1'b0;
               state_q <= C_WPULSE;
            end
            C_WPULSE:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q + 4'h1 == WP_LIM)
               begin
                  fl_we_n_q <= 1'b1;
                  state_q <= C_WHOLD;
               end
            end
            C_WHOLD:
            begin
               // Data stay driven one cycle past the rising write edge for hold time.
               fl_ce_n_q <= 1'b1;
               fl_dq_oe_n_q <= 1'b1;
               done_q <= 1'b1;
               state_q <= C_IDLE;
            end
            default:
            begin
               state_q <= C_IDLE;
            end
         endcase
      end
   end

endmodule

// ### sim/sqm_ctrl_sva.sv
// Purpose: Pin and port checks beside the sector-protect and query controller.
// Assumes: One clock domain; arst_n low resets everything.
// Notes: Query tracking follows the last command byte put on a write strobe.
`timescale 1ns/1ps
module sqm_ctrl_sva
(
   // Clock and reset
   input logic clock,
   input logic arst_n,
   // Register port
   input logic [3:0] reg_addr,
   input logic reg_rd,
   input logic [31:0] reg_rdata_q,
   // Flash pins
   input logic [20:0] fl_addr,
   input logic [15:0] fl_dq_o,
   input logic fl_dq_oe_n,
   input logic fl_ce_n,
   input logic fl_oe_n,
   input logic fl_we_n,
   input logic fl_byte_n_q,
   input logic fl_elevated_voltage_level_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic qry_q;
   always @(posedge clock or negedge arst_n)
      if (!arst_n)
         qry_q <= 1'h0;
      else if ($fell(fl_we_n))
         qry_q <= fl_dq_o[7:0] == 8'h98;
   strobe_excl_a: assert property (fl_oe_n || fl_we_n)
      else $error("read and write strobes low together");
   data_drive_a: assert property (!fl_dq_oe_n |-> fl_oe_n && !fl_ce_n)
      else $error("data driven outside a write cycle");
   write_pulse_a: assert property ($fell(fl_we_n) |-> !fl_ce_n ##1 !fl_we_n ##1 fl_we_n)
      else $error("write pulse not two cycles");
   read_len_a: assert property ($fell(fl_oe_n) |-> (!fl_oe_n && !fl_ce_n) [*4] ##[1:6] fl_oe_n)
      else $error("read cycle length wrong");
   query_addr_a: assert property ($fell(fl_we_n) && fl_dq_o[7:0] == 8'h98 |->
      fl_addr == (fl_byte_n_q ? 21'h55 : 21'haa)) else $error("query command at wrong address");
   query_read_a: assert property (qry_q && !fl_oe_n && fl_byte_n_q |-> fl_addr[20:7] == 14'h0)
      else $error("high address bits set in query read");
   prot_level_a: assert property ($fell(fl_we_n) && fl_dq_o[7:0] == 8'h60 |->
      $past(fl_elevated_voltage_level_q, 8)) else $error("protect write without settled level");
   unmapped_read_a: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata_q == 32'h0)
      else $error("unmapped index read not zero");
endmodule
bind sqm_ctrl sqm_ctrl_sva u_sva (.clock, .arst_n, .reg_addr, .reg_rd, .reg_rdata_q, .fl_addr, .fl_dq_o,
   .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_byte_n_q, .fl_elevated_voltage_level_q);

// ### sim/sqm_flash_model.sv
// Purpose: Behavioural flash device with sector protection and a query table.
// Assumes: Sectors are 32 Kword blocks; the top 8 Kwords form the boot sector.
// Notes: One stored word per sector keeps the model small.
`timescale 1ns/1ps
module sqm_flash_model
(
   // Flash bus
   input logic [20:0] fl_addr,
   output logic [15:0] fl_dq_i,
   input logic [15:0] fl_dq_o,
   input logic fl_ce_n,
   input logic fl_oe_n,
   input logic fl_we_n,
   // Control pins
   input logic fl_byte_n_q,
   input logic fl_reset_n_q,
   input logic fl_elevated_voltage_level_q,
   input logic fl_boot_lock_n_q
);
   logic [34:0] prot = '0;
   logic [15:0] mem [0:34];
   logic [1:0] mode = '0;
   logic [1:0] back = '0;
   logic pgm = '0;
   logic [19:0] wa;
   logic [5:0] sec;
   logic [15:0] v;
   logic blk;
   initial
      for (int i = 0; i < 35; i++)
         mem[i] = 16'hffff;
   function automatic logic [15:0] qry(input logic [6:0] a);
      case (a)
         7'h10: return 16'h51;
         7'h11: return 16'h52;
         7'h12: return 16'h59;
         7'h13: return 16'h2;
         7'h15: return 16'h40;
         7'h1b: return 16'h45;
         7'h1c: return 16'h55;
         7'h1f: return 16'h4;
         7'h21: return 16'ha;
         7'h23: return 16'h5;
         7'h25: return 16'h4;
         default: return 16'h0;
      endcase
   endfunction
   assign wa = fl_byte_n_q ? fl_addr[19:0] : fl_addr[20:1];
   assign sec = &wa[19:13] ? 6'h22 : {1'h0, wa[19:15]};
   assign blk = (sec == 6'h22 && !fl_boot_lock_n_q) || (prot[sec] && !fl_elevated_voltage_level_q);
   always_comb
   begin
      case (mode)
         2'h1: v = {15'h0, wa[1:0] == 2'h2 && prot[sec]};
         2'h2: v = fl_byte_n_q && |wa[19:7] ? 16'hdead : qry(wa[6:0]);
         default: v = mem[sec];
      endcase
      // Released bus shows the inverse so a stale value never passes.
      fl_dq_i = !fl_ce_n && !fl_oe_n ? v : ~v;
   end
   always @(posedge fl_we_n or negedge fl_reset_n_q)
      if (!fl_reset_n_q)
         mode <= 2'h0;
      else if (!fl_ce_n)
      begin
         pgm <= 1'h0;
         if (pgm)
            mem[sec] <= blk ? mem[sec] : mem[sec] & fl_dq_o;
         else if (fl_elevated_voltage_level_q && fl_dq_o[7:0] == 8'h60)
            prot <= wa[6] ? '0 : prot | (35'h1 << sec);
         else
            case (fl_dq_o[7:0])
               8'ha0: pgm <= mode == 2'h0;
               8'h90: if (mode == 2'h0) mode <= 2'h1;
               8'h98: if (mode != 2'h2 && wa == 20'h55) {back, mode} <= {mode, 2'h2};
               8'hf0: mode <= mode == 2'h2 ? back : 2'h0;
               default: ;
            endcase
      end
endmodule

// ### sim/sqm_ctrl_tb.sv
// Purpose: Self-checking bench for the sector-protect and query controller.
// Assumes: The flash model answers within the controller's read window.
// Notes: Operations poll busy at most 40 times; a hung operation stops polling and later checks fail.
`timescale 1ns/1ps
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module sqm_ctrl_tb;
   logic clock = '0;
   logic arst_n = '0;
   logic [3:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = '0;
   logic reg_rd = '0;
   wire [31:0] reg_rdata_q;
   wire [20:0] fl_addr;
   wire [15:0] fl_dq_i, fl_dq_o;
   wire fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n_q, fl_reset_n_q;
   wire fl_elevated_voltage_level_q, fl_boot_lock_n_q;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] d;
   // Expected query words from 10h up to 26h, low byte only.
   logic [0:22][7:0] qexp = 184'h51_52_59_02_00_40_00_00_00_00_00_45_55_00_00_04_00_0a_00_05_00_04_00;
   sqm_ctrl dut (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .fl_addr, .fl_dq_i,
      .fl_dq_o, .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_byte_n_q, .fl_reset_n_q,
      .fl_elevated_voltage_level_q, .fl_boot_lock_n_q);
   sqm_flash_model u_fl (.fl_addr, .fl_dq_i, .fl_dq_o, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_byte_n_q,
      .fl_reset_n_q, .fl_elevated_voltage_level_q, .fl_boot_lock_n_q);
   initial
      forever #10 clock = ~clock;
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1 d = reg_rdata_q;
   endtask
   task automatic chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
      rd(a);
      `CK(d & m, v)
   endtask
   // Busy only rises after the command edge, so the first poll already sees it.
   task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] v);
      wr(4'h1, a);
      wr(4'h2, v);
      wr(4'h3, {28'h0, c});
      d = 32'h1;
      for (int i = 0; i < 40 && d[0]; i++)
         rd(4'h4);
   endtask
   function automatic logic [31:0] sa(input int s);
      return s == 34 ? 32'hfe000 : s > 31 ? 32'hf8000 : s << 15;
   endfunction
   task automatic pg(input int s, input logic [31:0] v, input logic [31:0] e);
      op(4'h1, sa(s), 32'ha0);
      op(4'h1, sa(s), v);
      op(4'h2, sa(s), 32'h0);
      chk(4'h5, 32'hffff, e);
   endtask
   task automatic idm();
      op(4'h1, 32'h555, 32'h90);
      op(4'h5, 32'h0, 32'h0);
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      arst_n <= 1'h1;
      chk(4'h0, 32'hffffffff, 32'h0);
      chk(4'hf, 32'hffffffff, 32'h0);
      `CK(fl_boot_lock_n_q, 1'h0)
      `CK(fl_reset_n_q, 1'h1)
      idm();
      wr(4'h8, 32'h3);
      op(4'h6, sa(3), 32'h0);
      chk(4'h5, 32'hffff, 32'h0);
      op(4'h4, 32'h0, 32'hf0);
      op(4'h7, sa(3), 32'h60);
      chk(4'h6, 32'h8, 32'h8);
      idm();
      op(4'h6, sa(3), 32'h0);
      chk(4'h5, 32'hffff, 32'h1);
      op(4'h4, 32'h0, 32'hf0);
      wr(4'h0, 32'h2);
      pg(3, 32'h1234, 32'hffff);
      wr(4'h0, 32'h6);
      chk(4'h4, 32'h20, 32'h20);
      pg(3, 32'h1234, 32'h1234);
      wr(4'h0, 32'h2);
      chk(4'h4, 32'h20, 32'h0);
      pg(3, 32'h0, 32'h1234);
      wr(4'h0, 32'h4);
      pg(34, 32'hff, 32'hffff);
      wr(4'h0, 32'h2);
      pg(34, 32'hff, 32'hff);
      op(4'h8, 32'h40, 32'h60);
      chk(4'h4, 32'h8, 32'h8);
      wr(4'h4, 32'h8);
      for (int s = 0; s < 35; s++)
      begin
         wr(4'h8, s);
         op(4'h7, sa(s), 32'h60);
      end
      chk(4'h7, 32'hffffffff, 32'h7);
      op(4'h8, 32'h40, 32'h60);
      chk(4'h6, 32'hffffffff, 32'h0);
      chk(4'h7, 32'hffffffff, 32'h0);
      pg(3, 32'h0, 32'h0);
      op(4'h3, 32'h0, 32'h0);
      chk(4'h4, 32'h6, 32'h4);
      for (int a = 32'h10; a < 32'h27; a++)
      begin
         op(4'h2, a, 32'h0);
         chk(4'h5, 32'hffff, {24'h0, qexp[a - 16]});
      end
      chk(4'h4, 32'h10, 32'h10);
      op(4'h2, 32'h10010, 32'h0);
      chk(4'h5, 32'hffff, 32'h51);
      op(4'h3, 32'h0, 32'h0);
      chk(4'h4, 32'h8, 32'h8);
      op(4'h4, 32'h0, 32'hf0);
      chk(4'h4, 32'h6, 32'h0);
      idm();
      op(4'h3, 32'h0, 32'h0);
      op(4'h4, 32'h0, 32'hf0);
      chk(4'h4, 32'h6, 32'h2);
      `CK(u_fl.mode, 2'h1)
      op(4'h4, 32'h0, 32'hf0);
      wr(4'h0, 32'h3);
      op(4'h3, 32'h0, 32'h0);
      op(4'h2, 32'h20, 32'h0);
      chk(4'h5, 32'hff, 32'h51);
      give_verdict();
   end
endmodule
